// *** hdl/sabc_pkg.sv ***
// Package with constants and types for the converter bus control block
//==========================================================================
// Function
// - MSB-first approximation, eight bits, 64 clocks
// - Result latched straight binary, ones full-scale
// - Start falling clears register, shifter, done
// - Chip select and start low hold reset
// - Conversion begins 1 to 8 clocks after release
// - Select plus read clears done flop
// - Select plus read drives data, else float
// - New start aborts and restarts conversion
// - Start flop holds shifter, clears done, seeds
// - Gated pulse releases start flop when idle
// - Start still present keeps shifter held
// - One leaving last stage loads output latch
// - Exit flop next clock sets done low
// - Input samples spaced four and half clocks
// - Comparator strobed at end of each period
// - Whole conversion 66 to 73 clock periods
// - Start rising edge begins; held low resets
//==========================================================================
package sabc_pkg;
   localparam int unsigned DATA_W       = 8;          // Result width
   localparam int unsigned CLK_PER_BIT  = 8;          // Clocks per bit decision
   localparam int unsigned BIT_CNT_W    = 3;          // Phase counter width
   localparam logic [2:0]  PHASE_LAST   = 3'h7;       // Comparator strobe phase
   localparam logic [2:0]  PHASE_NEG    = 3'h4;       // Negative input sample phase
   localparam logic [7:0]  DATA_RESET   = 8'h00;      // Latch value after reset
   localparam logic [7:0]  MSB_ONLY     = 8'h80;      // Trial seed for first bit
   localparam logic [7:0]  SHIFT_CLEAR  = 8'h00;      // Empty shift register

   // Bus strobes, active low as on the pins
   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic rd_n;
   } sabc_strobe_s;

   // Sequencer states
   typedef enum logic [1:0] {
      SABC_IDLE,
      SABC_HOLD,
      SABC_CONV
   } sabc_state_e;
endpackage : sabc_pkg

// *** hdl/sabc_ctrl.sv ***
// Successive-approximation converter bus control block
`timescale 1ns/1ps
module sabc_ctrl
   import sabc_pkg::*;
#(
   parameter int unsigned WIDTH = DATA_W               // Result width
) (
   input  wire logic             SYS_CLK_IN,           // Converter clock
   input  wire logic             RESET_IN,             // Sync reset, active high
   input  wire logic             CS_N_IN,              // Chip select, active low
   input  wire logic             WR_N_IN,              // Start strobe, active low
   input  wire logic             RD_N_IN,              // Output enable, active low
   input  wire logic             COMP_IN,              // Comparator: input above trial
   output logic [WIDTH-1:0]      TRIAL_OUT,            // Trial word to the DAC
   output logic                  SAMPLE_POS_OUT,       // Sample positive input pulse
   output logic                  SAMPLE_NEG_OUT,       // Sample negative input pulse
   output logic                  COMP_STROBE_OUT,      // Comparator strobe pulse
   output logic [WIDTH-1:0]      DATA_OUT,             // Data pin drive value
   output logic                  DATA_OE_OUT,          // Data pin output enable
   output logic                  CONVERSION_DONE_N_OUT // Done flag, active low
);

   //=======================================================================
   // Strobe synchronisers
   //=======================================================================
   sabc_strobe_s sync1;                                 // First stage, only sync2 reads it
   sabc_strobe_s sync2;                                 // Clean strobes

   // Two flops per strobe; reset to idle-high
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         sync1 <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1};
         sync2 <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1};
      end else begin
         sync1 <= '{cs_n: CS_N_IN, wr_n: WR_N_IN, rd_n: RD_N_IN};
         sync2 <= sync1;
      end
   end

   //=======================================================================
   // Decode of bus conditions
   //=======================================================================
   wire start_req = ~sync2.cs_n & ~sync2.wr_n;
   wire read_req  = ~sync2.cs_n & ~sync2.rd_n;

   //=======================================================================
   // Sequencer registers
   //=======================================================================
   sabc_state_e            state;                       // Sequencer state
   logic                   start_flop;                  // Start flip-flop
   logic                   shift_entry_flop;            // Entry stage of shifter
   logic [WIDTH-1:0]       shift_reg;                   // One-hot bit pointer
   logic                   shift_exit_flop;             // Exit stage after shifter
   logic [BIT_CNT_W-1:0]   phase;                       // Clock within a bit
   logic [WIDTH-1:0]       sar;                         // Approximation register
   logic                   done_flop;                   // Done flip-flop
   logic [WIDTH-1:0]       result;                      // Output latch

   // Clock-gated release: entry holds the one and last phase of a slot
   wire start_release_gate = start_flop & shift_entry_flop &
                             (phase == PHASE_LAST) & ~start_req;
   wire bit_end            = (state == SABC_CONV) & (phase == PHASE_LAST);
   wire last_stage         = shift_reg[0];
   // One leaves last stage at the end of its slot
   wire result_load_gate   = bit_end & last_stage;

   // Decision for the bit under test: keep it if input is above trial
   function automatic logic [WIDTH-1:0] sabc_decide(input logic [WIDTH-1:0] word,
                                                    input logic [WIDTH-1:0] ptr,
                                                    input logic             keep);
      logic [WIDTH-1:0] cleared;
      cleared = word & ~ptr;
      sabc_decide = keep ? word : cleared;
   endfunction : sabc_decide

   wire [WIDTH-1:0] decided = sabc_decide(sar, shift_reg, COMP_IN);
   wire [WIDTH-1:0] next_sar = last_stage ? decided :
                               (decided | (shift_reg >> 1));

   //=======================================================================
   // Start flip-flop and entry stage
   //=======================================================================
   // Start sets on request, clears only via release gate; a second
   // start during conversion re-enters the hold and aborts
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         start_flop       <= 1'b0;
         shift_entry_flop <= 1'b0;
         phase            <= '0;
         state            <= SABC_IDLE;
      end else begin
         if (start_req) begin
            start_flop <= 1'b1;
         end else if (start_release_gate) begin
            start_flop <= 1'b0;
         end
         shift_entry_flop <= start_flop | start_req;
         // Free-running phase counter: gives the 1..8 clock start latency
         phase <= phase + 1'b1;
         case (state)
            SABC_IDLE: begin
               if (start_req) state <= SABC_HOLD;
            end
            SABC_HOLD: begin
               if (start_release_gate) state <= SABC_CONV;
            end
            SABC_CONV: begin
               if (start_req) state <= SABC_HOLD;
               else if (result_load_gate) state <= SABC_IDLE;
            end
            default: state <= SABC_IDLE;
         endcase
      end
   end

   //=======================================================================
   // Shift register and approximation register
   //=======================================================================
   // Shifter held clear while start flop is set
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN || start_req || start_flop) begin
         shift_reg <= SHIFT_CLEAR;
         sar       <= SHIFT_CLEAR;
         if (start_release_gate) begin
            shift_reg <= {1'b1, SHIFT_CLEAR[WIDTH-2:0]};
            sar       <= MSB_ONLY;
         end
      end else if (bit_end) begin
         shift_reg <= shift_reg >> 1;
         sar       <= next_sar;
      end
   end

   //=======================================================================
   // Result latch, exit flop and done flag
   //=======================================================================
   // Done set has priority over a read clear in the same cycle
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         result          <= DATA_RESET;
         shift_exit_flop <= 1'b0;
         done_flop       <= 1'b0;
      end else begin
         if (result_load_gate) result <= decided;
         shift_exit_flop <= result_load_gate & ~start_req;
         if (shift_exit_flop) begin
            done_flop <= 1'b1;
         end else if (start_req || start_flop || read_req) begin
            done_flop <= 1'b0;
         end
      end
   end

   //=======================================================================
   // Outputs
   //=======================================================================
   // Pin buffer value is registered; enable is a handshake level
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) DATA_OUT <= DATA_RESET;
      else          DATA_OUT <= result;
   end

   assign DATA_OE_OUT           = read_req;
   assign CONVERSION_DONE_N_OUT = ~done_flop;
   assign TRIAL_OUT             = sar;
   assign COMP_STROBE_OUT       = bit_end;
   // Positive at start of the first (MSB) slot only, negative four and a half clocks on
   assign SAMPLE_POS_OUT        = (state == SABC_CONV) & (phase == '0) & shift_reg[WIDTH-1];
   assign SAMPLE_NEG_OUT        = (state == SABC_CONV) & (phase == PHASE_NEG) &
                                  shift_reg[WIDTH-1] & ~SYS_CLK_IN;

endmodule : sabc_ctrl

// *** sim/sabc_ctrl_properties.sv ***
// Checker for the converter bus control block
`timescale 1ns/1ps
module sabc_ctrl_properties
   import sabc_pkg::*;
#(
   parameter int unsigned WIDTH = DATA_W
) (
   input wire logic             SYS_CLK_IN,
   input wire logic             RESET_IN,
   input wire logic             CS_N_IN,
   input wire logic             WR_N_IN,
   input wire logic             RD_N_IN,
   input wire logic             COMP_IN,
   input wire logic [WIDTH-1:0] TRIAL_OUT,
   input wire logic             SAMPLE_POS_OUT,
   input wire logic             SAMPLE_NEG_OUT,
   input wire logic             COMP_STROBE_OUT,
   input wire logic [WIDTH-1:0] DATA_OUT,
   input wire logic             DATA_OE_OUT,
   input wire logic             CONVERSION_DONE_N_OUT
);
   logic [7:0] since_go;  // Clocks since start released, saturating
   //==========================================================
   // Helper count; restarts while the start condition is present
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN || (!CS_N_IN && !WR_N_IN)) since_go <= 8'h00;
      else if (since_go != 8'hFF) since_go <= since_go + 8'h01;
   end
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (RESET_IN);
   // Strobes held past the two-flop synchroniser
   sequence s_read;  (!CS_N_IN && !RD_N_IN)[*3]; endsequence
   sequence s_start; (!CS_N_IN && !WR_N_IN)[*4]; endsequence
   a_oe_on_read: assert property (s_read |-> DATA_OE_OUT)
      else $error("Output enable missing during read");
   a_oe_off_idle: assert property ((CS_N_IN || RD_N_IN)[*3] |-> !DATA_OE_OUT)
      else $error("Output enable without read");
   a_start_done_high: assert property (s_start |-> CONVERSION_DONE_N_OUT)
      else $error("Done low while start held");
   a_held_no_step: assert property (s_start |-> !COMP_STROBE_OUT && !SAMPLE_POS_OUT)
      else $error("Sequencer moved while start held");
   a_read_clears: assert property (s_read ##0 !CONVERSION_DONE_N_OUT |=> CONVERSION_DONE_N_OUT)
      else $error("Read did not clear done");
   a_done_timing: assert property ($fell(CONVERSION_DONE_N_OUT) |-> since_go inside {[8'h40:8'h4C]})
      else $error("Conversion length out of range");
   a_bit_spacing: assert property (COMP_STROBE_OUT |=> !COMP_STROBE_OUT[*7])
      else $error("Bit decisions closer than eight clocks");
   a_sample_gap: assert property (SAMPLE_POS_OUT |-> ##[3:5] SAMPLE_NEG_OUT)
      else $error("Negative input sample not following");
   // Pin copy of the latch lags it one clock, so it moves on the edge that sets done
   a_load_then_done: assert property ($changed(DATA_OUT) |-> ##[0:1] $fell(CONVERSION_DONE_N_OUT))
      else $error("Result load not followed by done");
endmodule : sabc_ctrl_properties
bind sabc_ctrl sabc_ctrl_properties #(.WIDTH(WIDTH)) props_u (
   .SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN), .CS_N_IN(CS_N_IN), .WR_N_IN(WR_N_IN),
   .RD_N_IN(RD_N_IN), .COMP_IN(COMP_IN), .TRIAL_OUT(TRIAL_OUT), .SAMPLE_POS_OUT(SAMPLE_POS_OUT),
   .SAMPLE_NEG_OUT(SAMPLE_NEG_OUT), .COMP_STROBE_OUT(COMP_STROBE_OUT), .DATA_OUT(DATA_OUT),
   .DATA_OE_OUT(DATA_OE_OUT), .CONVERSION_DONE_N_OUT(CONVERSION_DONE_N_OUT));

// *** sim/sabc_host.sv ***
// Host model driving the converter strobes
`timescale 1ns/1ps
module sabc_host
   import sabc_pkg::*;
(
   input  wire logic start_req_in,  // Hold start strobe low
   input  wire logic read_req_in,   // Hold read strobe low
   input  wire logic free_run_in,   // Feed done back to start
   input  wire logic done_n_in,     // Done flag from converter
   output sabc_strobe_s pins_out    // Active-low strobes
);
   // Select low in free-run, else only while a strobe is asked for
   assign pins_out.cs_n = !(start_req_in || read_req_in || free_run_in);
   // Done loops to start in free-run; a kick pulse covers power-up
   assign pins_out.wr_n = !start_req_in && (!free_run_in || done_n_in);
   assign pins_out.rd_n = !read_req_in;
endmodule : sabc_host

// *** sim/sabc_ctrl_tb.sv ***
// Self-checking bench for the converter bus control block
`timescale 1ns/1ps
module sabc_ctrl_tb;
   import sabc_pkg::*;
   logic         clk = 1'b0, rst = 1'b1, comp = 1'b0;  // Clock, reset, comparator
   logic         start, rd, free, spos, sneg, cstb, oe, done_n, prev;
   logic [7:0]   vin, trial, data;                     // Input level, trial, result
   sabc_strobe_s pins;                                  // Host strobes
   int           n_errors, checked, n;
   logic [15:0]  rows [6] = '{16'h0000, 16'hFFFF, 16'hA5A5, 16'h5A5A, 16'h0101, 16'h8080};
   always #50 clk = ~clk;
   // Ideal comparator: keep bit while input at or above trial
   always @(negedge clk) comp <= (vin >= trial);
   sabc_host host_u (.start_req_in(start), .read_req_in(rd), .free_run_in(free),
      .done_n_in(done_n), .pins_out(pins));
   sabc_ctrl #(.WIDTH(DATA_W)) dut_u (.SYS_CLK_IN(clk), .RESET_IN(rst), .CS_N_IN(pins.cs_n),
      .WR_N_IN(pins.wr_n), .RD_N_IN(pins.rd_n), .COMP_IN(comp), .TRIAL_OUT(trial),
      .SAMPLE_POS_OUT(spos), .SAMPLE_NEG_OUT(sneg), .COMP_STROBE_OUT(cstb), .DATA_OUT(data),
      .DATA_OE_OUT(oe), .CONVERSION_DONE_N_OUT(done_n));
   //==========================================================
   // Tasks
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic results;
      $display("Checks %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   // Start held for hold clocks, then wait bounded for done
   task automatic convert(input logic [7:0] v, input int hold);
      vin = v;
      start = 1'b1;
      cyc(hold);
      chk("done_n held", 8'h01, {7'h00, done_n});
      start = 1'b0;
      n = 0;
      while (done_n !== 1'b0 && n < 200) begin
         cyc(1);
         n++;
      end
      chk("conv time", 8'h01, {7'h00, n >= 66 && n <= 76});
      if (n >= 200) results();
   endtask : convert
   task automatic read_chk(input logic [7:0] exp);
      rd = 1'b1;
      cyc(4);
      chk("oe on", 8'h01, {7'h00, oe});
      chk("data", exp, data);
      chk("done_n read", 8'h01, {7'h00, done_n});
      rd = 1'b0;
      cyc(4);
      chk("oe off", 8'h00, {7'h00, oe});
   endtask : read_chk
   //==========================================================
   // Main sequence
   initial begin
      {start, rd, free, vin, n_errors, checked} = '0;
      cyc(3);
      chk("reset done_n", 8'h01, {7'h00, done_n});
      chk("reset oe", 8'h00, {7'h00, oe});
      rst = 1'b0;
      cyc(1);
      foreach (rows[i]) begin
         convert(rows[i][15:8], 4);
         read_chk(rows[i][7:0]);
      end
      // Abort mid-run with a long held start
      convert(8'h33, 4);
      start = 1'b1;
      cyc(2);
      start = 1'b0;
      cyc(30);
      convert(8'hC3, 100);
      read_chk(8'hC3);
      // Free-running after one kick
      {free, n} = {1'b1, 32'd0};
      convert(8'h6D, 4);
      repeat (300) begin
         prev = done_n;
         cyc(1);
         if (prev === 1'b1 && done_n === 1'b0) n++;
      end
      chk("free runs", 8'h01, {7'h00, n >= 3});
      free = 1'b0;
      cyc(100);
      read_chk(8'h6D);
      // Reset in the middle of a conversion, then a clean conversion
      start = 1'b1;
      cyc(4);
      start = 1'b0;
      cyc(20);
      rst = 1'b1;
      cyc(3);
      chk("mid reset done_n", 8'h01, {7'h00, done_n});
      chk("mid reset oe", 8'h00, {7'h00, oe});
      chk("mid reset data", 8'h00, data);
      rst = 1'b0;
      cyc(1);
      convert(8'h5C, 4);
      read_chk(8'h5C);
      results();
   end
endmodule : sabc_ctrl_tb
